// [uaddr_defines.vh]
`ifndef UADDR_DEFINES_VH
`define UADDR_DEFINES_VH
// =====================================================================
// Register offsets (printed offsets are not all multiples of four)
`define UADDR_IDX_SLAVE_ADDRESS 8'ha9
`define UADDR_IDX_SLAVE_ADDRESS_MASK 8'hb9
`define UADDR_IDX_SERIAL_CONTROL 8'h98
`define UADDR_IDX_IRQ_STATUS 8'hc0
`define UADDR_IDX_IRQ_MASK 8'hc1
// =====================================================================
// Reset values
`define UADDR_RST_ADDR 8'h00
`define UADDR_RST_CTRL 8'h00
// =====================================================================
// Serial control fields
`define UADDR_CTL_MODE_LO 0
`define UADDR_CTL_MODE_HI 1
`define UADDR_CTL_MP_EN 2
`define UADDR_CTL_NINTH 3
`define UADDR_CTL_RFLAG 4
// =====================================================================
// Interrupt status fields and serial mode codes
`define UADDR_IRQ_RX 0
`define UADDR_IRQ_DROP 1
`define UADDR_MODE0 2'h0
`define UADDR_MODE1 2'h1
`endif

// [uaddr_filter.v]
// Local design decision: register access over APB.
`timescale 1ns/100ps
`include "uaddr_defines.vh"
module uaddr_filter #(
  parameter DATA_W = 8
) (
  input wire clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire rx_valid,
  input wire [DATA_W-1:0] rx_data,
  input wire rx_bit8,
  input wire rx_stop,
  output reg receive_flag,
  output reg received_ninth_bit,
  output reg [DATA_W-1:0] rx_byte,
  output reg irq
);
  // ===================================================================
  // Register select codes
  localparam SEL_NONE = 3'h0;
  localparam SEL_ADDR = 3'h1;
  localparam SEL_MASK = 3'h2;
  localparam SEL_CTRL = 3'h3;
  localparam SEL_STAT = 3'h4;
  localparam SEL_IMSK = 3'h5;
  localparam IRQ_W = 2;
  localparam PAD_W = 32 - DATA_W;

  // ===================================================================
  // Decode
  function [2:0] reg_sel;
    input [11:0] a;
    begin
      if (a[1:0] != 2'h0)
        reg_sel = SEL_NONE;
      else if (a[11:2] == {2'h0, `UADDR_IDX_SLAVE_ADDRESS})
        reg_sel = SEL_ADDR;
      else if (a[11:2] == {2'h0, `UADDR_IDX_SLAVE_ADDRESS_MASK})
        reg_sel = SEL_MASK;
      else if (a[11:2] == {2'h0, `UADDR_IDX_SERIAL_CONTROL})
        reg_sel = SEL_CTRL;
      else if (a[11:2] == {2'h0, `UADDR_IDX_IRQ_STATUS})
        reg_sel = SEL_STAT;
      else if (a[11:2] == {2'h0, `UADDR_IDX_IRQ_MASK})
        reg_sel = SEL_IMSK;
      else
        reg_sel = SEL_NONE;
    end
  endfunction

  // ===================================================================
  // Ninth bit source for the current mode
  function ninth_of;
    input [1:0] mode;
    input stop_bit;
    input bit_eight;
    begin
      if (mode == `UADDR_MODE1)
        ninth_of = stop_bit;
      else
        ninth_of = bit_eight;
    end
  endfunction

  // ===================================================================
  // One compared bit that disagrees
  function masked_miss;
    input data_bit;
    input ref_bit;
    input care_bit;
    begin
      masked_miss = (data_bit ^ ref_bit) & care_bit;
    end
  endfunction

  // ===================================================================
  // Storage and nets
  reg [DATA_W-1:0] slave_address;
  reg [DATA_W-1:0] slave_address_mask;
  reg [1:0] serial_mode;
  reg multiproc_enable;
  reg [IRQ_W-1:0] irq_status;
  reg [IRQ_W-1:0] irq_mask;
  reg [31:0] next_prdata;
  wire [2:0] sel;
  wire setup;
  wire wr;
  wire rd;
  wire wr_addr;
  wire wr_mask;
  wire wr_ctrl;
  wire wr_imsk;
  wire rd_stat;
  wire [DATA_W-1:0] bcast;
  wire [DATA_W-1:0] given_miss;
  wire [DATA_W-1:0] bcast_miss;
  wire given_hit;
  wire bcast_hit;
  wire filtering;
  wire qualifier;
  wire accept;
  wire next_ninth;
  wire frame_ok;
  wire frame_drop;
  wire flag_clear;
  wire [IRQ_W-1:0] irq_event;
  genvar gi;

  // ===================================================================
  // Bus phases and strobes
  assign sel = reg_sel(paddr);
  assign setup = psel && !penable;
  assign wr = psel && penable && pready && pwrite;
  assign rd = psel && penable && pready && !pwrite;
  assign wr_addr = wr && (sel == SEL_ADDR);
  assign wr_mask = wr && (sel == SEL_MASK);
  assign wr_ctrl = wr && (sel == SEL_CTRL);
  assign wr_imsk = wr && (sel == SEL_IMSK);
  assign rd_stat = rd && (sel == SEL_STAT);

  // ===================================================================
  // Address match, bit by bit
  assign bcast = slave_address | slave_address_mask;
  generate
    for (gi = 0; gi < DATA_W; gi = gi + 1) begin : g_bit
      assign given_miss[gi] = masked_miss(rx_data[gi], slave_address[gi],
        slave_address_mask[gi]);
      assign bcast_miss[gi] = masked_miss(rx_data[gi], bcast[gi],
        bcast[gi]);
    end
  endgenerate
  assign given_hit = ~|given_miss;
  assign bcast_hit = ~|bcast_miss;

  // ===================================================================
  // Frame acceptance
  assign filtering = multiproc_enable &&
    (serial_mode != `UADDR_MODE0);
  assign next_ninth = ninth_of(serial_mode, rx_stop, rx_bit8);
  assign qualifier = next_ninth;
  assign accept = !filtering ||
    ((given_hit || bcast_hit) && qualifier);
  assign frame_ok = rx_valid && accept;
  assign frame_drop = rx_valid && !accept;
  assign flag_clear = wr_ctrl && !pwdata[`UADDR_CTL_RFLAG];

  // ===================================================================
  // Read data mux
  always @* begin
    next_prdata = 32'h0;
    if (!pwrite) begin
      case (sel)
        SEL_ADDR: next_prdata = {{PAD_W{1'b0}}, slave_address};
        SEL_MASK: next_prdata = {{PAD_W{1'b0}}, slave_address_mask};
        SEL_CTRL: next_prdata = {27'h0, receive_flag, received_ninth_bit,
          multiproc_enable, serial_mode};
        SEL_STAT: next_prdata = {30'h0, irq_status};
        SEL_IMSK: next_prdata = {30'h0, irq_mask};
        default: next_prdata = 32'h0;
      endcase
    end
  end

  // ===================================================================
  // APB answer
  always @(posedge clk) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= setup;
      pslverr <= setup && (sel == SEL_NONE);
      if (setup) begin
        prdata <= next_prdata;
      end
    end
  end

  // ===================================================================
  // Address and mask registers
  always @(posedge clk) begin
    if (rst) begin
      slave_address <= `UADDR_RST_ADDR;
      slave_address_mask <= `UADDR_RST_ADDR;
    end else begin
      if (wr_addr) begin
        slave_address <= pwdata[DATA_W-1:0];
      end
      if (wr_mask) begin
        slave_address_mask <= pwdata[DATA_W-1:0];
      end
    end
  end

  // ===================================================================
  // Serial control and interrupt mask
  always @(posedge clk) begin
    if (rst) begin
      serial_mode <= `UADDR_MODE0;
      multiproc_enable <= 1'b0;
      irq_mask <= {IRQ_W{1'b0}};
    end else begin
      if (wr_ctrl) begin
        serial_mode <= pwdata[`UADDR_CTL_MODE_HI:`UADDR_CTL_MODE_LO];
        multiproc_enable <= pwdata[`UADDR_CTL_MP_EN];
      end
      if (wr_imsk) begin
        irq_mask <= pwdata[IRQ_W-1:0];
      end
    end
  end

  // ===================================================================
  // Receive flag, ninth bit, data
  always @(posedge clk) begin
    if (rst) begin
      receive_flag <= 1'b0;
      received_ninth_bit <= 1'b0;
      rx_byte <= {DATA_W{1'b0}};
    end else begin
      if (frame_ok) begin
        receive_flag <= 1'b1;
        received_ninth_bit <= next_ninth;
        rx_byte <= rx_data;
      end else if (flag_clear) begin
        receive_flag <= 1'b0;
      end
    end
  end

  // ===================================================================
  // Sticky status, set wins over read clear
  assign irq_event[`UADDR_IRQ_RX] = frame_ok;
  assign irq_event[`UADDR_IRQ_DROP] = frame_drop;
  generate
    for (gi = 0; gi < IRQ_W; gi = gi + 1) begin : g_irq
      always @(posedge clk) begin
        if (rst) begin
          irq_status[gi] <= 1'b0;
        end else begin
          irq_status[gi] <= irq_event[gi] ||
            (irq_status[gi] && !rd_stat);
        end
      end
    end
  endgenerate

  // ===================================================================
  // Interrupt output
  always @(posedge clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_mask);
    end
  end
endmodule // uaddr_filter

// [uaddr_filter_assertions.sv]
`timescale 1ns/100ps
// ==========
// Port checker
module uaddr_chk (
  input wire clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire rx_valid,
  input wire [7:0] rx_data,
  input wire receive_flag,
  input wire received_ninth_bit,
  input wire [7:0] rx_byte,
  input wire irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_ready_setup: assert property (psel && !penable |=> pready)
    else $error("ready late");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held");
  a_err_zero: assert property (pslverr |-> pready && prdata == 0)
    else $error("error data");
  a_flag_cause: assert property ($rose(receive_flag) |-> $past(rx_valid))
    else $error("flag cause");
  a_byte_load: assert property ($rose(receive_flag) |->
    rx_byte == $past(rx_data)) else $error("byte load");
  a_byte_hold: assert property (!$stable(rx_byte) |-> $past(rx_valid))
    else $error("byte change");
  a_ninth_hold: assert property
    (!$stable(received_ninth_bit) |-> $past(rx_valid)) else $error("ninth");
  a_irq_cause: assert property ($rose(irq) |->
    $past(rx_valid, 2) || $past(psel && penable && pwrite, 2))
    else $error("irq cause");
endmodule // uaddr_chk

// [uaddr_master.sv]
`timescale 1ns/100ps
// ==========
// Master node
module uaddr_master (
  input wire clk,
  output logic rx_valid = 1'b0,
  output logic [7:0] rx_data = 8'h00,
  output logic rx_bit8 = 1'b0,
  output logic rx_stop = 1'b0
);
  task send(input [7:0] d, input b, input s);
    @(posedge clk);
    rx_valid <= 1'b1;
    rx_data <= d;
    rx_bit8 <= b;
    rx_stop <= s;
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_data <= ~d;
    rx_bit8 <= ~b;
    rx_stop <= ~s;
  endtask
endmodule // uaddr_master

// [uaddr_filter_tb_top.sv]
`timescale 1ns/100ps
// ==========
// Bench
module uaddr_filter_tb_top;
  logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, ok, err;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, rdata, r;
  wire [31:0] prdata;
  wire pready, pslverr, rx_valid, rx_bit8, rx_stop, receive_flag, irq;
  wire received_ninth_bit;
  wire [7:0] rx_data, rx_byte;
  integer miscompares = 0, checks = 0, seed = 44448, i, n;
  logic [7:0] a, m, d;
  logic [1:0] md;
  logic mp, b8, st, mk;
  uaddr_filter DUT (.*);
  uaddr_master u_mst (.*);
  always #2.5 clk = ~clk;
  task chk(input [31:0] g, e);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task close_out;
    if (miscompares == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task apb(input [11:0] ad, input w, input [31:0] wd);
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, ad, wd};
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    @(negedge clk);
    while (pready !== 1'b1 && n < 40) begin
      n++;
      @(negedge clk);
    end
    if (n >= 40) begin
      miscompares++;
      $display("[FAIL] %0t no pready", $time);
    end
    rdata = prdata;
    err = pslverr;
    @(posedge clk);
    {psel, penable} <= 2'b00;
  endtask
  function logic f_acc;
    logic [7:0] b;
    b = a | m;
    f_acc = !mp || md == 0 || (((((d ^ a) & m) == 0) ||
      (((d ^ b) & b) == 0)) && (md == 1 ? st : b8));
  endfunction
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    apb(12'h2a4, 0, 0);
    chk(rdata, 0);
    apb(12'h2e4, 0, 0);
    chk(rdata, 0);
    apb(12'h004, 0, 0);
    chk(err, 1);
    chk(rdata, 0);
    for (i = 0; i < 60; i++) begin
      r = $random(seed);
      {a, m, d, md, mp, b8, st, mk} = r[29:0];
      if (i % 3 == 0) d = a;
      if (i % 3 == 1) d = 8'hff;
      if (i % 5 == 0) m = 8'hff;
      ok = f_acc();
      apb(12'h260, 1, {mp, md});
      apb(12'h2a4, 1, a);
      apb(12'h2e4, 1, m);
      apb(12'h304, 1, mk);
      apb(12'h2e4, 0, 0);
      chk(rdata, m);
      apb(12'h300, 0, 0);
      u_mst.send(d, b8, st);
      repeat (2) @(posedge clk);
      #1 chk(receive_flag, ok);
      chk(irq, ok & mk);
      if (ok) chk({rx_byte, received_ninth_bit}, {d, md == 1 ? st : b8});
      apb(12'h300, 0, 0);
      chk(rdata, {!ok, ok});
    end
    close_out;
  end
  initial begin
    #100000;
    miscompares++;
    close_out;
  end
endmodule // uaddr_filter_tb_top
bind uaddr_filter uaddr_chk u_chk (.*);
